// ---- rtl/smrr_top.sv ----
`timescale 1ns/1ps
`include "smrr_defs.svh"
// Overview of operation
// R1 - Opcode 02EH runs routine 14 and replies one byte: the sampled AGC voltage.
// R2 - Eight calibration bytes live in page 2 at addresses 01F4H to 01FBH.
// R3 - Page-select opcode low nibble picks the page; 052H page 2, 050H page 0.
// R4 - High-register-load opcode puts its nibble into H; 03FH gives 15.
// R5 - Address-low-set makes low address byte from H and nibble; 044H gives 00F4H.
// R6 - Address-high-set puts nibble above the low byte; 011H makes 01F4H.
// R7 - Memory-byte-read replies byte at page and address, then address plus one.
// R8 - All command and reply bytes are full eight-bit binary, bit 7 kept.
// R9 - Host sends only opcodes, never CR, LF, null or end-of-file bytes.
// R10 - First cal byte is AGC at -113dBm; later bytes are 10dB or 20dB increments.
// R11 - Host subtracts cal bytes in turn, then interpolates the remainder.
// R12 - Attenuation sits at page 0 location 49 in 10dB units; host adds it.
// R13 - Host reads the table once at connect, then returns to page 0.
// R14 - Host enables AGC and sets full front-end gain before sampling.
// R15 - Each received byte is one opcode: high nibble operation, low nibble operand.
module smrr_top
  import smrr_pkg::*;
(
  input  wire logic             clk_sys,        // System clock, 200 MHz
  input  wire logic             rst,            // Synchronous reset, active high
  input  wire smrr_byte_type    cmdIn,          // Received byte from the serial receiver
  output smrr_byte_type         replyOut,       // Reply byte toward the serial transmitter
  input  wire logic [7:0]       agcLevelPin,    // AGC voltage converter output
  input  wire logic [7:0]       frontEndAttenuationLevelPin, // Auto attenuator state, 10dB units
  input  wire smrr_apb_req_type apbReq,         // APB request
  output smrr_apb_rsp_type      apbRsp          // APB response
);

  typedef struct packed {
    logic [3:0]                     page;
    logic [3:0]                     hreg;
    logic [11:0]                    addr;
    logic [`SMRR_CAL_BYTES-1:0][7:0] cal;
    logic [7:0]                     agcLast;
    logic [7:0]                     agcMeta;
    logic [7:0]                     agcSync;
    logic [7:0]                     attMeta;
    logic [7:0]                     attSync;
    smrr_byte_type                  reply;
    smrr_apb_rsp_type               rsp;
  } smrr_state_type;

  smrr_state_type state_reg;
  smrr_state_type state_next;

  // Byte visible to the link at a page and address
  function automatic logic [7:0] readByte(
    input smrr_state_type s,
    input logic [3:0]     page,
    input logic [11:0]    addr
  );
    logic [11:0] idx;
    idx = addr - `SMRR_CAL_FIRST;
    readByte = `SMRR_RST_BYTE;
    if (page == `SMRR_CAL_PAGE && addr >= `SMRR_CAL_FIRST
        && addr <= `SMRR_CAL_LAST) begin                        // [R2]
      readByte = s.cal[idx[2:0]];                                 // [R10]
    end else if (page == `SMRR_ATTEN_PAGE && addr == `SMRR_ATTEN_ADDR) begin
      readByte = s.attSync;                                       // [R12]
    end
  endfunction : readByte

  logic [3:0]  opCode;
  logic [3:0]  operand;
  logic        apbAccess;
  logic [11:0] calIdx;

  assign opCode  = cmdIn.data[7:4];                              // [R15]
  assign operand = cmdIn.data[3:0];
  assign apbAccess = apbReq.psel && apbReq.penable && !state_reg.rsp.pready;
  assign calIdx  = apbReq.paddr - `SMRR_REG_CAL_BASE;

  always_comb begin
    state_next = state_reg;
    state_next.reply.valid = 1'b0;
    state_next.rsp.pready  = 1'b0;
    state_next.rsp.pslverr = 1'b0;
    // Two flops before any logic looks at the pins; levels change slowly
    state_next.agcMeta = agcLevelPin;
    state_next.agcSync = state_reg.agcMeta;
    state_next.attMeta = frontEndAttenuationLevelPin;
    state_next.attSync = state_reg.attMeta;

    if (cmdIn.valid) begin
      unique case (opCode)
        `SMRR_OP_ADDR_HIGH: begin
          state_next.addr = {operand, state_reg.addr[7:0]};      // [R6]
        end
        `SMRR_OP_EXECUTE: begin
          if (operand == `SMRR_ROUTINE_AGC) begin
            state_next.agcLast     = state_reg.agcSync;          // [R1]
            state_next.reply.valid = 1'b1;                       // [R1]
            state_next.reply.data  = state_reg.agcSync;          // [R8]
          end
        end
        `SMRR_OP_HREG_LOAD: begin
          state_next.hreg = operand;                             // [R4]
        end
        `SMRR_OP_ADDR_LOW: begin
          state_next.addr = {state_reg.addr[11:8], state_reg.hreg, operand}; // [R5]
        end
        `SMRR_OP_PAGE_SELECT: begin
          state_next.page = operand;                             // [R3]
        end
        `SMRR_OP_MEM_READ: begin
          state_next.reply.valid = 1'b1;                         // [R7]
          state_next.reply.data  = readByte(state_reg, state_reg.page, state_reg.addr); // [R8]
          state_next.addr        = state_reg.addr + 12'h001;     // [R7]
        end
        default: begin
          // Unused operations are ignored so a stray byte cannot stall the link
        end
      endcase
    end

    // APB slave: one wait state, every access answered
    if (apbAccess) begin
      state_next.rsp.pready = 1'b1;
      state_next.rsp.prdata = `SMRR_RST_WORD;
      if (apbReq.paddr < `SMRR_REG_STATUS && apbReq.paddr[1:0] == 2'b00) begin
        if (apbReq.pwrite) begin
          state_next.cal[calIdx[4:2]] = apbReq.pwdata[7:0];      // [R2]
        end else begin
          state_next.rsp.prdata = {24'h000000, state_reg.cal[calIdx[4:2]]};
        end
      end else if (apbReq.paddr == `SMRR_REG_STATUS && !apbReq.pwrite) begin
        state_next.rsp.prdata = {12'h000, state_reg.page, state_reg.hreg, state_reg.addr};
      end else if (apbReq.paddr == `SMRR_REG_AGC && !apbReq.pwrite) begin
        state_next.rsp.prdata = {24'h000000, state_reg.agcLast};
      end else if (apbReq.paddr == `SMRR_REG_ATTEN && !apbReq.pwrite) begin
        state_next.rsp.prdata = {24'h000000, state_reg.attSync};
      end else begin
        state_next.rsp.pslverr = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_reg.page    <= `SMRR_RST_PAGE;
      state_reg.hreg    <= `SMRR_RST_HREG;
      state_reg.addr    <= `SMRR_RST_ADDR;
      state_reg.cal     <= '0;
      state_reg.agcLast <= `SMRR_RST_BYTE;
      state_reg.agcMeta <= `SMRR_RST_BYTE;
      state_reg.agcSync <= `SMRR_RST_BYTE;
      state_reg.attMeta <= `SMRR_RST_BYTE;
      state_reg.attSync <= `SMRR_RST_BYTE;
      state_reg.reply   <= '0;
      state_reg.rsp     <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign replyOut = state_reg.reply;
  assign apbRsp   = state_reg.rsp;

endmodule : smrr_top

// ---- rtl/smrr_defs.svh ----
`ifndef SMRR_DEFS_SVH
`define SMRR_DEFS_SVH

// Opcode high nibbles
`define SMRR_OP_ADDR_HIGH   4'h1
`define SMRR_OP_EXECUTE     4'h2
`define SMRR_OP_HREG_LOAD   4'h3
`define SMRR_OP_ADDR_LOW    4'h4
`define SMRR_OP_PAGE_SELECT 4'h5
`define SMRR_OP_MEM_READ    4'h7

// Routine numbers carried in the execute operand
`define SMRR_ROUTINE_AGC    4'hE

// Memory map seen by the byte link
`define SMRR_CAL_PAGE       4'h2
`define SMRR_CAL_FIRST      12'h1F4
`define SMRR_CAL_LAST       12'h1FB
`define SMRR_ATTEN_PAGE     4'h0
`define SMRR_ATTEN_ADDR     12'h031
`define SMRR_CAL_BYTES      8

// APB register byte offsets
`define SMRR_REG_CAL_BASE   12'h000
`define SMRR_REG_STATUS     12'h020
`define SMRR_REG_AGC        12'h024
`define SMRR_REG_ATTEN      12'h028

// Reset values
`define SMRR_RST_PAGE       4'h0
`define SMRR_RST_HREG       4'h0
`define SMRR_RST_ADDR       12'h000
`define SMRR_RST_BYTE       8'h00
`define SMRR_RST_WORD       32'h0000_0000

`endif

// ---- rtl/smrr_pkg.sv ----
package smrr_pkg;

  typedef struct packed {
    logic        valid;
    logic [7:0]  data;
  } smrr_byte_type;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } smrr_apb_req_type;

  typedef struct packed {
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
  } smrr_apb_rsp_type;

endpackage : smrr_pkg

// ---- tb/smrr_props.sv ----
`timescale 1ns/1ps
module smrr_props
  import smrr_pkg::*;
(
  input wire logic             clk_sys,  // Clock
  input wire logic             rst,      // Reset
  input wire smrr_byte_type    cmdIn,    // Command byte
  input wire smrr_byte_type    replyOut, // Reply byte
  input wire smrr_apb_req_type apbReq,   // APB request
  input wire smrr_apb_rsp_type apbRsp    // APB response
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  a_agc_reply: assert property (cmdIn.valid && cmdIn.data == 8'h2E |=> replyOut.valid)
    else $error("no reply to sample");
  a_read_reply: assert property (cmdIn.valid && cmdIn.data[7:4] == 4'h7 |=> replyOut.valid)
    else $error("no reply to read");
  a_setup_silent: assert property (cmdIn.valid && cmdIn.data[7:4] inside {4'h1, 4'h3, 4'h4,
    4'h5} |=> !replyOut.valid) else $error("reply to setup byte");
  a_reply_cause: assert property (replyOut.valid |-> $past(cmdIn.valid) &&
    ($past(cmdIn.data) == 8'h2E || ($past(cmdIn.data) >> 4) == 8'h07))
    else $error("reply without cause");
  a_data_hold: assert property (!replyOut.valid |-> $stable(replyOut.data))
    else $error("reply data moved");
  a_apb_wait: assert property (apbReq.psel && apbReq.penable && !apbRsp.pready
    |=> apbRsp.pready) else $error("ready late");
  a_ready_pulse: assert property (apbRsp.pready |=> !apbRsp.pready)
    else $error("ready held");
  a_err_ready: assert property (apbRsp.pslverr |-> apbRsp.pready)
    else $error("error without ready");
  c_sample: cover property (cmdIn.valid && cmdIn.data == 8'h2E);
  c_read: cover property (replyOut.valid);
  c_slverr: cover property (apbRsp.pslverr);
endmodule : smrr_props

bind smrr_top smrr_props u_smrr_props (.clk_sys(clk_sys), .rst(rst), .cmdIn(cmdIn),
  .replyOut(replyOut), .apbReq(apbReq), .apbRsp(apbRsp));

// ---- tb/smrr_host.sv ----
`timescale 1ns/1ps
module smrr_host
  import smrr_pkg::*;
(
  input wire logic    clk_sys, // Clock
  output smrr_byte_type cmdIn  // Byte toward the interpreter
);
  initial cmdIn = '0;
  // Whole binary bytes, never any framing byte
  task automatic send(input logic [7:0] b);
    @(posedge clk_sys);
    cmdIn <= '{valid: 1'b1, data: b};
    @(posedge clk_sys);
    cmdIn <= '{valid: 1'b0, data: ~b}; // Stale byte not left on the line
  endtask : send
  // Host-side conversion: walk the table, then share out the remainder in the next step
  function automatic int level_dbm(input logic [7:0]      agc,
                                   input logic [7:0][7:0] tbl,
                                   input logic [7:0]      atten);
    int rest;
    int lvl;
    int step;
    rest = int'(agc) - int'(tbl[0]);
    lvl  = -113;
    if (rest < 0) return lvl + 10 * int'(atten);
    for (int k = 1; k < 8; k++) begin
      step = (k >= 6) ? 20 : 10;
      if (rest < int'(tbl[k])) return lvl + rest * step / int'(tbl[k]) + 10 * int'(atten);
      rest = rest - int'(tbl[k]);
      lvl  = lvl + step;
    end
    return lvl + 10 * int'(atten);
  endfunction : level_dbm
endmodule : smrr_host

// ---- tb/smrr_top_test.sv ----
`timescale 1ns/1ps
module smrr_top_test
  import smrr_pkg::*;
;
  logic             clk_sys = 1'b0;
  logic             rst = 1'b1;
  smrr_byte_type    cmdIn, replyOut;
  logic [7:0]       agcLevelPin = 8'h00, attPin = 8'h00, lastRep;
  smrr_apb_req_type apbReq = '0;
  smrr_apb_rsp_type apbRsp;
  logic [31:0]      rd;
  logic             err;
  int               err_count = 0, compares = 0, nRep = 0;
  always #2.5 clk_sys = ~clk_sys;
  smrr_top u_smrr_top (.clk_sys(clk_sys), .rst(rst), .cmdIn(cmdIn), .replyOut(replyOut),
    .agcLevelPin(agcLevelPin), .frontEndAttenuationLevelPin(attPin), .apbReq(apbReq),
    .apbRsp(apbRsp));
  smrr_host u_smrr_host (.clk_sys(clk_sys), .cmdIn(cmdIn));
  always @(posedge clk_sys) if (replyOut.valid === 1'b1) begin
    nRep    <= nRep + 1;
    lastRep <= replyOut.data;
  end
  function automatic logic [7:0] cal(int i);
    return 8'(8'h81 + 8'h13 * i);
  endfunction : cal
  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s exp %h seen %h", what, exp, seen);
    end
  endtask : check
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    apbReq <= '{1'b1, 1'b0, wr, a, d};
    @(posedge clk_sys);
    apbReq.penable <= 1'b1;
    do @(posedge clk_sys); while (apbRsp.pready !== 1'b1);
    rd = apbRsp.prdata;
    err = apbRsp.pslverr;
    apbReq <= '0;
  endtask : apb
  task link(input logic [7:0] b, input logic rep, input logic [7:0] exp);
    int n;
    n = nRep;
    u_smrr_host.send(b);
    @(posedge clk_sys);
    #1;
    check("reply count", 32'(nRep - n), 32'(rep));
    if (rep) check("reply byte", lastRep, exp);
  endtask : link
  task final_report;
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : final_report
  initial begin
    #60000;
    err_count++;
    final_report;
  end
  initial begin
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    attPin <= 8'h07;
    for (int i = 0; i < 8; i++) apb(1'b1, 12'(4 * i), 32'(cal(i)));
    apb(1'b0, 12'h01C, '0);
    check("cal7", rd, 32'(cal(7)));
    check("cal7 no err", 32'(err), 32'h0);
    link(8'h52, 1'b0, 8'h00);
    link(8'h3F, 1'b0, 8'h00);
    link(8'h44, 1'b0, 8'h00);
    link(8'h11, 1'b0, 8'h00);
    for (int i = 0; i < 8; i++) link(8'h71, 1'b1, cal(i));
    apb(1'b0, 12'h020, '0);
    check("status", rd, 32'h0002_F1FC);
    $display("test table walk done");
    link(8'h50, 1'b0, 8'h00);
    link(8'h33, 1'b0, 8'h00);
    link(8'h41, 1'b0, 8'h00);
    link(8'h10, 1'b0, 8'h00);
    link(8'h71, 1'b1, 8'h07);
    @(posedge clk_sys) agcLevelPin <= 8'hC8; // AGC level C8 driven straight onto the pin
    repeat (3) @(posedge clk_sys);
    link(8'h2E, 1'b1, 8'hC8);
    apb(1'b0, 12'h024, '0);
    check("agc reg", rd, 32'h0000_00C8);
    apb(1'b0, 12'h028, '0);
    check("atten reg", rd, 32'h0000_0007);
    check("level", 32'(u_smrr_host.level_dbm(8'h64, {8'h14, 8'h1E, 8'h0F, 8'h0C,
      8'h0C, 8'h0A, 8'h0A, 8'h40}, 8'h00)), 32'(-80));
    check("level atten", 32'(u_smrr_host.level_dbm(8'h64, {8'h14, 8'h1E, 8'h0F, 8'h0C,
      8'h0C, 8'h0A, 8'h0A, 8'h40}, 8'h07)), 32'(-10));
    $display("test attenuation and sample done");
    link(8'h60, 1'b0, 8'h00);
    link(8'h2F, 1'b0, 8'h00);
    link(8'hF5, 1'b0, 8'h00);
    apb(1'b0, 12'h030, '0);
    check("unmapped err", 32'(err), 32'h1);
    apb(1'b1, 12'h020, 32'hFFFF_FFFF);
    check("ro write err", 32'(err), 32'h1);
    apb(1'b0, 12'h020, '0);
    check("status kept", rd, 32'h0000_3032);
    $display("test refusals done");
    // Held four edges so the reply data settles before checks resume
    @(posedge clk_sys) rst <= 1'b1;
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    apb(1'b0, 12'h020, '0);
    check("status after reset", rd, 32'h0000_0000);
    apb(1'b0, 12'h000, '0);
    check("cal0 after reset", rd, 32'h0000_0000);
    link(8'h2E, 1'b1, 8'hC8);
    $display("test mid-run reset done");
    final_report;
  end
endmodule : smrr_top_test
